// File: src/ccp_map.svh
// register map, field positions and mode codes of the two-unit capture/compare block
// assumes a 12-bit APB byte address and 32-bit data, one register per aligned word
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH

// register byte offsets
`define OFS_U1_CTL 12'h000
`define OFS_U1_DL 12'h004
`define OFS_U1_DH 12'h008
`define OFS_U2_CTL 12'h00C
`define OFS_U2_DL 12'h010
`define OFS_U2_DH 12'h014
`define OFS_T3_CTL 12'h018
`define OFS_T3_CL 12'h01C
`define OFS_T3_CH 12'h020
`define OFS_STAT 12'h024

// unit_mode_control fields
`define CTL_MODE_LSB 0
`define CTL_DUTY_LSB 4

// timer3_control fields
`define T3_ON_BIT 0
`define T3_CS_BIT 1
`define T3_SYNC_BIT 2
`define T3_ASGN_LO_BIT 3
`define T3_ASGN_HI_BIT 6

// status fields
`define ST_T3OVF 0
`define ST_U1EV 1
`define ST_U2EV 2
`define ST_T3ASYNC 3
`define ST_T1ASYNC 4

// reset values
`define CTL_RESET 6'h00
`define T3CTL_RESET 8'h00
`define DATA_RESET 16'h0000

// mode_select_field codes
`define MODE_OFF 4'h0
`define MODE_TOGGLE 4'h2
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_4 4'h6
`define MODE_CAP_16 4'h7
`define MODE_SET_HIGH 4'h8
`define MODE_SET_LOW 4'h9
`define MODE_SW_EVENT 4'hA
`define MODE_SPECIAL 4'hB

`endif

// File: src/ccp_mode_and_timer_trigger.sv
// top of the two-unit capture/compare block: APB registers, timer assignment,
// special event trigger, timer3 counter and pwm duty staging
// assumes timers 1 and 2 sit outside; all inputs synchronous to pclk
//
// Operation
// R01 - timer3-based unit in special mode resets timer3 count on match
// R02 - special reset is only dependable while timer3 is not an asynchronous counter
// R03 - unit 2 data pair acts as timer3 period in special mode
// R04 - software write to timer3 count beats a same-cycle special reset
// R05 - special reset never sets the timer3 overflow flag
// R06 - each unit holds one 16-bit data register for capture, compare, duty
// R07 - data pair is two software read/write bytes; control also read/write
// R08 - control bits 7 and 6 always read zero
// R09 - control bits 5:4 are the low two bits of the 10-bit duty
// R10 - mode 0000 disables and clears the unit; 0001, 0011 reserved
// R11 - mode 0010 toggles the pin on match and sets the event flag
// R12 - modes 0100-0111 capture on fall, rise, 4th rise, 16th rise
// R13 - mode 1000 starts pin low, forces high on match, sets flag
// R14 - mode 1001 starts pin high, forces low on match, sets flag
// R15 - mode 1010 sets only the flag; pin left to port latch
// R16 - mode 1011 sets flag, pulses special event, resets timer, asks conversion
// R17 - pwm modes 11xx use timer2; capture and compare use timer1 or timer3
// R18 - both units may run and share a timer chosen by assignment bits
// R19 - capture is not dependable on an asynchronous timer1
// R20 - pin fuse routes unit 2 to port c pin 1 when set, else port b pin 3
// R21 - only unit 2 special event starts a conversion, and only when enabled
// R22 - pwm units share timer2 and update duty on the same timer2 event
// R23 - assign bits: 1x timer3 for both, 01 timer3 for unit 2, 00 timer1
// R24 - unit event flag stays set until software clears it
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "ccp_map.svh"
module ccp_mode_and_timer_trigger import ccp_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer1 and timer2 outside
	input wire logic [15:0] timer1_count,
	input wire logic timer1_async,
	output logic timer1_reset,
	input wire logic timer2_update,
	// timer3 clocking
	input wire logic timer3_ext_tick,
	// a/d converter
	input wire logic adc_enabled,
	output logic adc_start,
	// unit 1 pin
	input wire logic unit1_pin_in,
	output logic unit1_pin_out,
	output logic unit1_pin_oe,
	// unit 2 pin choices
	input wire logic unit2_pin_select_fuse,
	input wire logic port_c_pin_1_in,
	output logic port_c_pin_1_out,
	output logic port_c_pin_1_oe,
	input wire logic port_b_pin_3_in,
	output logic port_b_pin_3_out,
	output logic port_b_pin_3_oe,
	// pwm duty for the pwm datapath
	output logic [9:0] pwm_duty1,
	output logic [9:0] pwm_duty2
);
	top_state_t q, d;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic setup, wr;
	logic mapped;
	logic [31:0] rd;
	logic wr_t3ctl, wr_t3l, wr_t3h, wr_stat;

	assign setup = psel & !penable;
	assign wr = psel & penable & pwrite;
	// zero wait states: every access phase completes at once
	assign pready = 1'b1;
	assign pslverr = psel & penable & !mapped;
	assign prdata = q.prdata;

	assign wr_t3ctl = wr && (paddr == `OFS_T3_CTL);
	assign wr_t3l = wr && (paddr == `OFS_T3_CL);
	assign wr_t3h = wr && (paddr == `OFS_T3_CH);
	assign wr_stat = wr && (paddr == `OFS_STAT);

	// ------------------------------------------------------------
	// timer assignment
	// ------------------------------------------------------------
	logic [1:0] uses_t3;
	logic [1:0] pwm_mode;
	logic [1:0][3:0] mode;
	logic [1:0][15:0] base;
	logic [1:0][15:0] udata;
	logic [1:0] ev;
	logic [1:0] sp;
	logic [1:0] pin_in;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] wr_ctl, wr_dl, wr_dh;
	logic [15:0] t3_count;
	logic t3_ovf;
	logic t3_special;
	logic t3_async;

	assign uses_t3[0] = q.t3ctl[`T3_ASGN_HI_BIT]; // see R23
	assign uses_t3[1] = q.t3ctl[`T3_ASGN_HI_BIT] | q.t3ctl[`T3_ASGN_LO_BIT]; // see R23

	// ------------------------------------------------------------
	// the two units
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_unit
			localparam logic [11:0] OFS_CTL = (gi == 0) ? `OFS_U1_CTL : `OFS_U2_CTL;
			localparam logic [11:0] OFS_DL = (gi == 0) ? `OFS_U1_DL : `OFS_U2_DL;
			localparam logic [11:0] OFS_DH = (gi == 0) ? `OFS_U1_DH : `OFS_U2_DH;

			assign wr_ctl[gi] = wr && (paddr == OFS_CTL);
			assign wr_dl[gi] = wr && (paddr == OFS_DL);
			assign wr_dh[gi] = wr && (paddr == OFS_DH);
			assign mode[gi] = q.ctl[gi][3:0];
			assign pwm_mode[gi] = (mode[gi][3:2] == 2'b11); // see R17
			// both units may pick the same timer; no arbitration needed
			assign base[gi] = uses_t3[gi] ? t3_count : timer1_count; // see R18

			ccp_unit u_unit (
				.pclk(pclk),
				.presetn(presetn),
				.mode(mode[gi]),
				.timer_count(base[gi]),
				.pin_in(pin_in[gi]),
				.wr_low(wr_dl[gi]),
				.wr_high(wr_dh[gi]),
				.wdata(pwdata[7:0]),
				.data(udata[gi]),
				.event_pulse(ev[gi]),
				.special_pulse(sp[gi]),
				.pin_out(pin_out[gi]),
				.pin_oe(pin_oe[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// pin routing
	// ------------------------------------------------------------
	assign pin_in[0] = unit1_pin_in;
	assign pin_in[1] = unit2_pin_select_fuse ? port_c_pin_1_in : port_b_pin_3_in; // see R20
	assign unit1_pin_out = pin_out[0];
	assign unit1_pin_oe = pin_oe[0];
	// the fuse moves both the signal and its output enable; the other pin is not driven
	assign port_c_pin_1_out = unit2_pin_select_fuse & pin_out[1]; // see R20
	assign port_c_pin_1_oe = unit2_pin_select_fuse & pin_oe[1];
	assign port_b_pin_3_out = !unit2_pin_select_fuse & pin_out[1];
	assign port_b_pin_3_oe = !unit2_pin_select_fuse & pin_oe[1];

	// ------------------------------------------------------------
	// timer3 and the special event
	// ------------------------------------------------------------
	// unit 2 data then works as the timer3 period
	assign t3_special = (sp[0] & uses_t3[0]) | (sp[1] & uses_t3[1]); // see R01 see R03
	// reset is still applied in async mode, but it may land on a torn count
	assign t3_async = q.t3ctl[`T3_CS_BIT] & q.t3ctl[`T3_SYNC_BIT]; // see R02

	timer3_counter u_t3 (
		.pclk(pclk),
		.presetn(presetn),
		.on(q.t3ctl[`T3_ON_BIT]),
		.ext_sel(q.t3ctl[`T3_CS_BIT]),
		.ext_tick(timer3_ext_tick),
		.special_reset(t3_special),
		.wr_low(wr_t3l),
		.wr_high(wr_t3h),
		.wdata(pwdata[7:0]),
		.count(t3_count),
		.ovf(t3_ovf)
	);

	assign timer1_reset = q.t1_rst;
	assign adc_start = q.adc_start;
	assign pwm_duty1 = q.duty[0];
	assign pwm_duty2 = q.duty[1];

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		rd = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			`OFS_U1_CTL: rd = {26'h000_0000, q.ctl[0]}; // see R08
			`OFS_U1_DL: rd = {24'h00_0000, udata[0][7:0]};
			`OFS_U1_DH: rd = {24'h00_0000, udata[0][15:8]};
			`OFS_U2_CTL: rd = {26'h000_0000, q.ctl[1]}; // see R08
			`OFS_U2_DL: rd = {24'h00_0000, udata[1][7:0]};
			`OFS_U2_DH: rd = {24'h00_0000, udata[1][15:8]};
			`OFS_T3_CTL: rd = {24'h00_0000, q.t3ctl};
			`OFS_T3_CL: rd = {24'h00_0000, t3_count[7:0]};
			`OFS_T3_CH: rd = {24'h00_0000, t3_count[15:8]};
			// async flags warn that reset and capture cannot be trusted
			`OFS_STAT: rd = {27'h000_0000, timer1_async, t3_async, q.flags}; // see R02 see R19
			default: mapped = 1'b0;
		endcase
		if (setup) begin
			d.prdata = rd;
		end
		for (int i = 0; i < 2; i++) begin
			if (wr_ctl[i]) begin
				d.ctl[i] = pwdata[5:0]; // see R07
			end
			// duty low bits only matter in pwm; staged on the shared timer2 event
			if (timer2_update && pwm_mode[i]) begin
				d.duty[i] = {udata[i][7:0], q.ctl[i][`CTL_DUTY_LSB +: 2]}; // see R09 see R22
			end
			// set wins over a same-cycle write-one clear
			d.flags[i + 1] = (q.flags[i + 1] & !(wr_stat & pwdata[i + 1])) | ev[i]; // see R24
		end
		d.flags[`ST_T3OVF] = (q.flags[`ST_T3OVF] & !(wr_stat & pwdata[`ST_T3OVF])) | t3_ovf; // see R05
		if (wr_t3ctl) begin
			d.t3ctl = pwdata[7:0];
		end
		d.t1_rst = (sp[0] & !uses_t3[0]) | (sp[1] & !uses_t3[1]); // see R16
		// unit 1 special event resets its timer but never converts
		d.adc_start = sp[1] & adc_enabled; // see R21
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.ctl <= {`CTL_RESET, `CTL_RESET};
			q.t3ctl <= `T3CTL_RESET;
			q.flags <= 3'h0;
			q.prdata <= 32'h0000_0000;
			q.duty <= 20'h0_0000;
			q.t1_rst <= 1'b0;
			q.adc_start <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ctl_top_zero_a: assert property (psel && penable && !pwrite && paddr == `OFS_U2_CTL |-> prdata[31:6] == 26'h0) // see R08
		else $error("control upper bits not zero");
	t3_special_reset_a: assert property (t3_special && !wr_t3l && !wr_t3h |=> t3_count == 16'h0000) // see R01
		else $error("timer3 not reset by special event");
	t3_write_wins_a: assert property (t3_special && wr_t3l |=> t3_count[7:0] == $past(pwdata[7:0])) // see R04
		else $error("special reset beat software write");
	no_ovf_special_a: assert property (t3_special |-> !t3_ovf) // see R05
		else $error("special reset raised overflow");
	adc_unit2_only_a: assert property (adc_start |-> $past(sp[1]) && $past(adc_enabled)) // see R21
		else $error("conversion start without unit 2 event");
	assign_both_t3_a: assert property (q.t3ctl[`T3_ASGN_HI_BIT] |-> uses_t3 == 2'b11 && base[0] == t3_count) // see R23
		else $error("timer assignment wrong");
	duty_stage_a: assert property (timer2_update && pwm_mode[0] |=> pwm_duty1 == $past({udata[0][7:0], q.ctl[0][5:4]})) // see R22
		else $error("pwm duty not staged on timer2 event");
	flag_sticky_a: assert property (q.flags[1] && !(wr_stat && pwdata[1]) |=> q.flags[1]) // see R24
		else $error("event flag dropped without clear");
	flag_set_a: assert property (ev[1] |=> q.flags[2]) // see R24
		else $error("unit 2 event lost");

	special_seen_c: cover property (t3_special ##1 t3_count == 16'h0000);
	adc_seen_c: cover property (adc_start);
	capture_seen_c: cover property (ev[0] && mode[0][3:2] == 2'b01);
	pwm_seen_c: cover property (timer2_update && pwm_mode == 2'b11);
endmodule : ccp_mode_and_timer_trigger

// File: src/ccp_pkg.sv
// state types of the capture/compare block and its timer3 counter
// assumes ccp_map.svh for the numbers
package ccp_pkg;
	typedef struct packed {
		logic [15:0] data;
		logic [3:0] mode_prev;
		logic pin_prev;
		logic match_prev;
		logic [3:0] presc;
		logic cmp_out;
	} unit_state_t;

	typedef struct packed {
		logic [15:0] count;
	} t3_state_t;

	typedef struct packed {
		logic [1:0][5:0] ctl;
		logic [7:0] t3ctl;
		logic [2:0] flags;
		logic [31:0] prdata;
		logic [1:0][9:0] duty;
		logic t1_rst;
		logic adc_start;
	} top_state_t;
endpackage : ccp_pkg

// File: src/ccp_unit.sv
// one capture/compare unit: data register, capture edges, compare pin actions
// assumes pin_in is synchronous and timer_count is the selected time base
`timescale 1ns/1ps
`include "ccp_map.svh"
module ccp_unit import ccp_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// configuration and time base
	input wire logic [3:0] mode,
	input wire logic [15:0] timer_count,
	input wire logic pin_in,
	// software access to the data pair
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [7:0] wdata,
	// results
	output logic [15:0] data,
	output logic event_pulse,
	output logic special_pulse,
	output logic pin_out,
	output logic pin_oe
);
	unit_state_t q, d;
	logic cap, cmp, rise, fall, eq, hit, cap_ev;

	assign cap = (mode[3:2] == 2'b01);
	assign cmp = (mode == `MODE_TOGGLE) || (mode[3:2] == 2'b10);
	assign rise = pin_in & !q.pin_prev;
	assign fall = !pin_in & q.pin_prev;
	assign eq = (timer_count == q.data);
	assign hit = cmp & eq & !q.match_prev;
	assign cap_ev = cap & ((mode == `MODE_CAP_FALL) ? fall : rise) & ((mode == `MODE_CAP_4) ? (q.presc == 4'h3) :
		(mode == `MODE_CAP_16) ? (q.presc == 4'hF) : 1'b1); // see R12
	assign event_pulse = hit | cap_ev;
	assign special_pulse = hit & (mode == `MODE_SPECIAL); // see R16
	assign data = q.data;
	assign pin_out = q.cmp_out;
	// sw-event and special modes leave the pin to its port latch
	assign pin_oe = (mode == `MODE_TOGGLE) || (mode == `MODE_SET_HIGH) || (mode == `MODE_SET_LOW); // see R15

	always_comb begin
		d = q;
		d.pin_prev = pin_in;
		d.mode_prev = mode;
		d.match_prev = eq;
		if (!cap) begin
			d.presc = 4'h0;
		end else if (rise && (mode == `MODE_CAP_4 || mode == `MODE_CAP_16)) begin
			d.presc = cap_ev ? 4'h0 : q.presc + 4'h1;
		end
		if (mode != q.mode_prev && mode == `MODE_SET_HIGH) begin
			d.cmp_out = 1'b0; // see R13
		end
		if (mode != q.mode_prev && mode == `MODE_SET_LOW) begin
			d.cmp_out = 1'b1; // see R14
		end
		if (hit) begin
			unique case (mode)
				`MODE_TOGGLE: d.cmp_out = !q.cmp_out; // see R11
				`MODE_SET_HIGH: d.cmp_out = 1'b1; // see R13
				`MODE_SET_LOW: d.cmp_out = 1'b0; // see R14
				default: d.cmp_out = q.cmp_out;
			endcase
		end
		if (cap_ev) begin
			d.data = timer_count; // see R06
		end
		if (mode == `MODE_OFF) begin
			d.cmp_out = 1'b0; // see R10
			d.presc = 4'h0;
			d.match_prev = 1'b0;
		end
		if (wr_low) begin
			d.data[7:0] = wdata; // see R07
		end
		if (wr_high) begin
			d.data[15:8] = wdata; // see R07
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	toggle_on_match_a: assert property (hit && mode == `MODE_TOGGLE && !(mode != q.mode_prev) |=> pin_out != $past(pin_out)) // see R11
		else $error("toggle mode did not flip the pin");
	force_level_a: assert property (hit && mode[3:1] == 3'b100 |=> pin_out == !$past(mode[0])) // see R13
		else $error("forced compare level wrong");
endmodule : ccp_unit

// File: src/timer3_counter.sv
// timer3 count pair with special-event reset and byte writes
// assumes ext_tick is one pclk wide and synchronous
`timescale 1ns/1ps
`include "ccp_map.svh"
module timer3_counter import ccp_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic on,
	input wire logic ext_sel,
	input wire logic ext_tick,
	input wire logic special_reset,
	// software access
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [7:0] wdata,
	// result
	output logic [15:0] count,
	output logic ovf
);
	t3_state_t q, d;
	logic tick;

	assign tick = on & (ext_sel ? ext_tick : 1'b1);
	// a reset or a write in the same cycle steals the wrap
	assign ovf = tick & (q.count == 16'hFFFF) & !special_reset & !wr_low & !wr_high; // see R05
	assign count = q.count;

	always_comb begin
		d = q;
		if (tick) begin
			d.count = q.count + 16'h0001;
		end
		if (special_reset) begin
			d.count = 16'h0000; // see R01
		end
		// software write overrides the special-event reset
		if (wr_low) begin
			d.count[7:0] = wdata; // see R04
		end
		if (wr_high) begin
			d.count[15:8] = wdata; // see R04
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : timer3_counter

// File: verification/ccp_far_side_model.sv
// far side of the capture/compare block: timer1, timer2 period pulse, a/d start counter
// assumes every input is synchronous to pclk and arrives one cycle wide where it is a pulse
`timescale 1ns/1ps
module ccp_far_side_model #(
	parameter int T2_PERIOD = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// timer1
	input wire logic t1_run,
	input wire logic t1_clear,
	input wire logic timer1_reset,
	output logic [15:0] timer1_count,
	// timer2 and converter
	output logic timer2_update,
	input wire logic adc_start,
	output logic [7:0] adc_starts
);
	int t2_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer1_count <= 16'h0000;
			t2_cnt <= 0;
			timer2_update <= 1'b0;
			adc_starts <= 8'h00;
		end else begin
			// a special event ends the timer1 period, so it restarts from zero
			if (t1_clear || timer1_reset) begin
				timer1_count <= 16'h0000;
			end else if (t1_run) begin
				timer1_count <= timer1_count + 16'h0001;
			end
			t2_cnt <= (t2_cnt == T2_PERIOD - 1) ? 0 : t2_cnt + 1;
			timer2_update <= (t2_cnt == T2_PERIOD - 1);
			// counted whether or not the converter is enabled: the bench judges that
			adc_starts <= adc_starts + {7'h00, adc_start};
		end
	end
endmodule : ccp_far_side_model

// File: verification/ccp_mode_and_timer_trigger_tb_top.sv
// self-checking bench of the two-unit capture/compare block, registers over apb
// assumes the far-side model provides timer1 and timer2 and counts a/d starts
`timescale 1ns/1ps
`include "ccp_map.svh"
module ccp_mode_and_timer_trigger_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] t1c;
	logic t1_run, t1_clear, t1rst, t2u, adc_en, adc_st, u1_drv, u1_pin, u1o, u1oe, fuse, pco, pcoe, pbo, pboe;
	logic t1_async, ext_tick;
	logic [9:0] d1, d2;
	logic [7:0] adc_n, n0;
	logic [3:0] cmp_mode [3] = '{`MODE_SET_HIGH, `MODE_SET_LOW, `MODE_TOGGLE};
	int err_count, compares, v, i, m;

	// the wire level follows the unit while it drives, the bench otherwise
	assign u1_pin = u1oe ? u1o : u1_drv;

	ccp_mode_and_timer_trigger ccp_mode_and_timer_trigger_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer1_count(t1c), .timer1_async(t1_async), .timer1_reset(t1rst), .timer2_update(t2u),
		.timer3_ext_tick(ext_tick), .adc_enabled(adc_en), .adc_start(adc_st),
		.unit1_pin_in(u1_pin), .unit1_pin_out(u1o), .unit1_pin_oe(u1oe), .unit2_pin_select_fuse(fuse),
		.port_c_pin_1_in(pcoe ? pco : 1'b1), .port_c_pin_1_out(pco), .port_c_pin_1_oe(pcoe),
		.port_b_pin_3_in(pboe ? pbo : 1'b1), .port_b_pin_3_out(pbo), .port_b_pin_3_oe(pboe),
		.pwm_duty1(d1), .pwm_duty2(d2)
	);
	ccp_far_side_model ccp_far_side_model_inst (
		.pclk(pclk), .presetn(presetn), .t1_run(t1_run), .t1_clear(t1_clear), .timer1_reset(t1rst),
		.timer1_count(t1c), .timer2_update(t2u), .adc_start(adc_st), .adc_starts(adc_n)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	// one apb transfer; read data and error flag land in q and err_q
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// writes in order: each entry is address over data
	task automatic wrs(input logic [43:0] ops[$]);
		foreach (ops[k]) apb(1'b1, ops[k][43:32], ops[k][31:0]);
	endtask : wrs

	// timer1 runs three counts, then stands; the pin then pulses high
	task automatic pin_pulse;
		t1_run <= 1'b1;
		tick(3);
		t1_run <= 1'b0;
		tick(1);
		u1_drv <= 1'b1;
		tick(3);
		u1_drv <= 1'b0;
		tick(3);
	endtask : pin_pulse

	task automatic report_and_stop;
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (30000) @(posedge pclk);
		err_count++;
		report_and_stop;
	end

	initial begin
		{presetn, psel, penable, pwrite, t1_run, t1_clear, adc_en, u1_drv, t1_async, ext_tick} = 10'h000;
		fuse = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		err_count = 0;
		compares = 0;
		v = $urandom(98);
		tick(4);
		presetn <= 1'b1;
		tick(1);
		for (i = 0; i < 10; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0);
			chk("reset value", q, 32'h0);
		end
		apb(1'b1, 12'h028, 32'hFFFF_FFFF);
		apb(1'b0, 12'h028, 32'h0);
		chk("unmapped", {q[30:0], err_q}, 32'h1);
		for (i = 0; i < 7; i++) begin
			v = $urandom;
			apb(1'b1, 12'(i * 4), v);
			apb(1'b0, 12'(i * 4), 32'h0);
			chk("readback", q, v & ((i % 3 == 0 && i < 6) ? 32'h3F : 32'hFF));
			apb(1'b1, 12'(i * 4), 32'h0);
		end
		// timer assignment: the matching unit is the one on the standing timer1
		t1_clear <= 1'b1;
		tick(1);
		t1_clear <= 1'b0;
		pin_pulse;
		for (m = 0; m < 4; m++) begin
			wrs('{{`OFS_U1_CTL, 32'h0}, {`OFS_U2_CTL, 32'h0}, {`OFS_T3_CTL, 25'h0, m[1], 2'b00, m[0], 3'b000},
				{`OFS_T3_CH, 32'h0}, {`OFS_T3_CL, 32'hFF}, {`OFS_U1_DL, 32'h0}, {`OFS_U2_DL, 32'h0},
				{`OFS_STAT, 32'h7}, {`OFS_U1_CTL, 28'h0, `MODE_SW_EVENT}, {`OFS_U2_CTL, 28'h0, `MODE_SW_EVENT},
				{`OFS_U1_DL, 24'h0, t1c[7:0]}, {`OFS_U2_DL, 24'h0, t1c[7:0]}});
			apb(1'b0, `OFS_STAT, 32'h0);
			chk("assign flags", q[2:1], {m == 0, m < 2});
			chk("event pin oe", u1oe, 1'b0);
		end
		// capture edges, prescaler counted from zero after the unit is off
		apb(1'b1, `OFS_T3_CTL, 32'h0);
		for (m = 0; m < 4; m++) begin
			wrs('{{`OFS_U1_CTL, 32'h0}, {`OFS_U1_CTL, 32'(`MODE_CAP_FALL + m)}});
			apb(1'b0, `OFS_U1_DL, 32'h0);
			v = q;
			repeat (m < 2 ? 0 : (m == 2 ? 3 : 15)) pin_pulse;
			apb(1'b0, `OFS_U1_DL, 32'h0);
			chk("capture early", q, v);
			pin_pulse;
			apb(1'b0, `OFS_U1_DL, 32'h0);
			chk("capture", q, {24'h0, t1c[7:0]});
		end
		wrs('{{`OFS_U1_CTL, 32'h0}, {`OFS_STAT, 32'h2}});
		apb(1'b0, `OFS_STAT, 32'h0);
		chk("flag cleared", q[1], 1'b0);
		// compare pin actions on a standing timer1
		for (m = 0; m < 3; m++) begin
			wrs('{{`OFS_U1_CTL, 32'h0}, {`OFS_U1_DL, 24'h0, t1c[7:0] + 8'h01}});
			tick(1);
			chk("off pin", u1o, 1'b0);
			wrs('{{`OFS_U1_CTL, 28'h0, cmp_mode[m]}, {`OFS_STAT, 32'h7}});
			tick(1);
			chk("entry pin", {u1oe, u1o}, {1'b1, m == 1});
			apb(1'b1, `OFS_U1_DL, {24'h0, t1c[7:0]});
			tick(3);
			chk("match pin", u1o, m != 1);
			apb(1'b0, `OFS_STAT, 32'h0);
			chk("match flag", q[1], 1'b1);
		end
		// timer3 overflow, then unit 2 special event on timer3
		v = 40 + $urandom % 40;
		wrs('{{`OFS_U1_CTL, 32'h0}, {`OFS_T3_CTL, 32'h1}, {`OFS_T3_CH, 32'hFF}, {`OFS_T3_CL, 32'hF0}});
		tick(20);
		apb(1'b0, `OFS_STAT, 32'h0);
		chk("overflow", q[0], 1'b1);
		wrs('{{`OFS_T3_CTL, 32'h8}, {`OFS_T3_CH, 32'h0}, {`OFS_T3_CL, 32'h0}, {`OFS_U2_DL, v},
			{`OFS_U2_DH, 32'h0}, {`OFS_U2_CTL, 28'h0, `MODE_SPECIAL}, {`OFS_STAT, 32'h7}});
		n0 = adc_n;
		adc_en <= 1'b1;
		apb(1'b1, `OFS_T3_CTL, 32'h9);
		tick(400);
		i = adc_n - n0;
		apb(1'b0, `OFS_T3_CL, 32'h0);
		chk("t3 period", q <= v, 1'b1);
		apb(1'b0, `OFS_T3_CH, 32'h0);
		chk("t3 high", q, 32'h0);
		apb(1'b0, `OFS_STAT, 32'h0);
		chk("special status", q[2:0], 3'b100);
		chk("adc starts", i >= 3 && i <= 400 / v + 1, 1'b1);
		adc_en <= 1'b0;
		tick(2);
		n0 = adc_n;
		tick(200);
		chk("adc disabled", adc_n, n0);
		// count lands on v two edges after the first write, so the second write meets the special reset
		wrs('{{`OFS_T3_CL, v - 2}, {`OFS_T3_CL, 32'h10}});
		apb(1'b0, `OFS_T3_CL, 32'h0);
		chk("t3 write wins", q, 32'h11);
		// unit 1 special event restarts timer1 and never starts a conversion
		wrs('{{`OFS_U2_CTL, 32'h0}, {`OFS_T3_CTL, 32'h0}, {`OFS_U1_DL, 32'h20}, {`OFS_U1_CTL, 32'hB}});
		adc_en <= 1'b1;
		t1_clear <= 1'b1;
		tick(1);
		t1_clear <= 1'b0;
		t1_run <= 1'b1;
		n0 = adc_n;
		tick(200);
		t1_run <= 1'b0;
		tick(1);
		chk("t1 period", t1c <= 16'h0021, 1'b1);
		chk("adc from unit 1", adc_n, n0);
		// timer3 on external ticks as an unsynchronised counter; both async states show in status
		t1_async <= 1'b1;
		wrs('{{`OFS_T3_CL, 32'h0}, {`OFS_T3_CH, 32'h0}, {`OFS_T3_CTL, 32'h7}});
		repeat (5) begin
			ext_tick <= 1'b1;
			tick(1);
			ext_tick <= 1'b0;
			tick(2);
		end
		apb(1'b0, `OFS_T3_CL, 32'h0);
		chk("t3 ext ticks", q, 32'h5);
		apb(1'b0, `OFS_STAT, 32'h0);
		chk("async status", q[4:3], 2'b11);
		t1_async <= 1'b0;
		// pwm duty staging on the shared timer2 event
		for (i = 0; i < 3; i++) begin
			v = $urandom;
			wrs('{{`OFS_U1_DL, 24'h0, v[7:0]}, {`OFS_U1_CTL, 26'h0, v[9:8], 4'hC},
				{`OFS_U2_DL, 24'h0, v[17:10]}, {`OFS_U2_CTL, 26'h0, v[19:18], 2'b11, v[21:20]}});
			tick(40);
			chk("duty 1", d1, {v[7:0], v[9:8]});
			chk("duty 2", d2, {v[17:10], v[19:18]});
		end
		// unit 2 pin routing by the fuse level
		wrs('{{`OFS_U2_DH, 32'hFF}, {`OFS_U2_CTL, 28'h0, `MODE_SET_LOW}});
		for (m = 0; m < 2; m++) begin
			fuse <= m[0];
			tick(3);
			chk("port c pin", {pcoe, pco}, {m[0], m[0]});
			chk("port b pin", {pboe, pbo}, {!m[0], !m[0]});
		end
		report_and_stop;
	end
endmodule : ccp_mode_and_timer_trigger_tb_top
